// ### src/core_timing_pkg.sv
// Constants and types shared by the execution sequencer and its breakpoint comparators.
// Assumes a single system clock; no software-visible registers.
package core_timing_pkg;
  localparam int unsigned PC_W = 16;
  localparam int unsigned CNT_W = 4;
  localparam int unsigned RAM_DEPTH = 256;
  localparam int unsigned RAM_AW = 8;
  localparam int unsigned NUM_BP = 4;
  // Instruction mix of the set, kept for reference only; no file uses it. see RQ6
  localparam int unsigned NUM_INSTR = 109;
  localparam int unsigned NUM_ONE_CLK = 26;
  localparam int unsigned NUM_TWO_CLK = 50;
  localparam logic [CNT_W-1:0] MAX_CYCLES = 4'h8;
  localparam logic [CNT_W-1:0] BRANCH_NOT_TAKEN_SAVING = 4'h2;
  localparam logic [CNT_W-1:0] CODE_READ_MIN_CYCLES = 4'h4;
  localparam logic [CNT_W-1:0] CODE_READ_MAX_CYCLES = 4'h7;
  localparam logic [CNT_W-1:0] PREFETCH_OFF_PENALTY = 4'h1;
  localparam logic [CNT_W-1:0] CNT_MAX = 4'hf;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [7:0] RAM_RESET_DATA = 8'h00;
  localparam logic [PC_W-1:0] ADDR_RESET = 16'h0000;

  typedef enum logic [2:0] {
    CLS_LEN = 3'b000,
    CLS_FIXED = 3'b001,
    CLS_BRANCH = 3'b010,
    CLS_CODE_READ = 3'b011,
    CLS_FLASH_WR = 3'b100,
    CLS_FLASH_ER = 3'b101
  } instr_class_t;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_HALTED = 2'b01,
    ST_STEP = 2'b10
  } run_state_t;
endpackage : core_timing_pkg

// ### src/bp_bus.sv
// Carrier between the sequencer and its breakpoint comparators.
// Assumes one comparator per hit bit, each driving only its own bit.
`timescale 1ns/1ps
interface bp_bus #(parameter int unsigned N = 4);
  import core_timing_pkg::*;
  logic [PC_W-1:0] pc;
  wire [N-1:0] hit;
  modport core (output pc, input hit);
  modport unit (input pc, output hit);
endinterface : bp_bus

// ### src/bp_compare.sv
// One hardware breakpoint comparator.
// Assumes the address and enable are held stable by the debug logic.
`timescale 1ns/1ps
module bp_compare #(
  parameter int unsigned IDX = 0
) (
  input wire logic [core_timing_pkg::PC_W-1:0] match_addr,
  input wire logic match_en,
  bp_bus.unit bus
);
  import core_timing_pkg::*;
  assign bus.hit[IDX] = match_en && (bus.pc == match_addr); // see RQ9
endmodule : bp_compare

// ### src/exec_sequencer.sv
// Instruction timing sequencer, debug run control and internal data RAM of the core.
// Assumes decode supplies class, length and table cycles; debug requests come
// from the two-wire debug interface logic on the same clock.
//
// Summary of operation
// RQ1: Decoded behaviour equals the standard instruction set.
// RQ2: All durations counted in system clocks only.
// RQ3: Most instructions take cycles equal to bytes.
// RQ4: Untaken conditional branch finishes two cycles sooner.
// RQ5: No instruction exceeds eight cycles; an untaken branch is not capped (up to 13) and prefetch off adds PF_PENALTY.
// RQ6: 109 instructions; 26 one-clock, 50 two-clock.
// RQ7: Peak one instruction per clock.
// RQ8: Software reads and writes flash bytewise.
// RQ9: Breakpoints, start, stop, single step supported.
// RQ10: Debug uses no user resources, runs nonintrusively.
// RQ11: Programming and debug use two-wire interface.
// RQ12: 256 bytes of internal data RAM.
// RQ13: Cycle counts hold with prefetch enabled.
// RQ14: Code-memory reads take four to seven cycles.
// RQ15: External-data move can write or erase flash.
// RQ16: Halt finishes current instruction, then reports halted.
`timescale 1ns/1ps
module exec_sequencer #(
  parameter logic [3:0] PF_PENALTY = core_timing_pkg::PREFETCH_OFF_PENALTY
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic issue_valid,
  output logic issue_ready,
  input wire logic [core_timing_pkg::PC_W-1:0] issue_pc,
  input wire core_timing_pkg::instr_class_t issue_class,
  input wire logic [1:0] issue_len,
  input wire logic [core_timing_pkg::CNT_W-1:0] issue_table_cycles,
  input wire logic branch_taken,
  input wire logic code_read_misaligned,
  input wire logic [core_timing_pkg::PC_W-1:0] xdata_addr,
  input wire logic [7:0] xdata_wdata,
  input wire logic prefetch_enable,
  input wire logic [1:0] flash_read_timing,
  output logic retire,
  output logic busy,
  output logic flash_write_stb,
  output logic flash_erase_stb,
  output logic [core_timing_pkg::PC_W-1:0] flash_addr,
  output logic [7:0] flash_wdata,
  input wire logic dbg_halt_req,
  input wire logic dbg_step_req,
  input wire logic dbg_resume_req,
  input wire logic [core_timing_pkg::NUM_BP*core_timing_pkg::PC_W-1:0] bp_addr,
  input wire logic [core_timing_pkg::NUM_BP-1:0] bp_en,
  output logic halted,
  output logic halt_by_bp,
  input wire logic ram_en,
  input wire logic ram_we,
  input wire logic [core_timing_pkg::RAM_AW-1:0] ram_addr,
  input wire logic [7:0] ram_wdata,
  output logic [7:0] ram_rdata,
  input wire logic dbg_ram_en,
  input wire logic dbg_ram_we,
  input wire logic [core_timing_pkg::RAM_AW-1:0] dbg_ram_addr,
  input wire logic [7:0] dbg_ram_wdata,
  output logic [7:0] dbg_ram_rdata
);
  import core_timing_pkg::*;

  run_state_t state_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic [CNT_W-1:0] cycles;
  logic halt_pend_reg;
  logic bp_skip_reg;
  logic halt_by_bp_reg;
  logic accept;
  logic bp_stop;
  logic near_done;
  logic halt_now;
  logic [7:0] mem [RAM_DEPTH];
  logic [7:0] ram_rdata_reg;
  logic [7:0] dbg_ram_rdata_reg;
  logic flash_write_stb_reg;
  logic flash_erase_stb_reg;
  logic [PC_W-1:0] flash_addr_reg;
  logic [7:0] flash_wdata_reg;

  bp_bus #(.N(NUM_BP)) bpb ();

  assign bpb.pc = issue_pc;

  for (genvar i = 0; i < NUM_BP; i++) begin : g_bp
    bp_compare #(.IDX(i)) u_bp (
      .match_addr(bp_addr[i*PC_W +: PC_W]),
      .match_en(bp_en[i]),
      .bus(bpb.unit)
    );
  end

  // Cycle cost per class; decode has already matched opcode semantics. see RQ1
  function automatic logic [CNT_W-1:0] cycles_of(
    input instr_class_t cls,
    input logic [1:0] len,
    input logic [CNT_W-1:0] tbl,
    input logic taken,
    input logic misal,
    input logic [1:0] rd_wait,
    input logic pf_on
  );
    logic [CNT_W-1:0] c;
    c = CNT_ONE;
    unique case (cls)
      CLS_LEN, CLS_FLASH_WR, CLS_FLASH_ER: c = {2'b00, len}; // see RQ3
      CLS_FIXED: c = (tbl > MAX_CYCLES) ? MAX_CYCLES : tbl; // see RQ5 see RQ6
      CLS_BRANCH: begin
        // Not-taken path skips the target fetch. see RQ4
        if (taken || tbl <= BRANCH_NOT_TAKEN_SAVING) begin
          c = (tbl > MAX_CYCLES) ? MAX_CYCLES : tbl; // see RQ5
        end else begin
          c = tbl - BRANCH_NOT_TAKEN_SAVING;
        end
      end
      CLS_CODE_READ: begin
        c = CODE_READ_MIN_CYCLES + {3'b000, misal} + {2'b00, rd_wait}; // see RQ14
        if (c > CODE_READ_MAX_CYCLES) begin
          c = CODE_READ_MAX_CYCLES;
        end
      end
      default: c = {2'b00, len};
    endcase
    if (c == CNT_ZERO) begin
      c = CNT_ONE;
    end
    // Table figures assume prefetch on; without it each fetch stalls. see RQ13
    if (!pf_on) begin
      c = (c > CNT_MAX - PF_PENALTY) ? CNT_MAX : c + PF_PENALTY;
    end
    return c;
  endfunction : cycles_of

  assign cycles = cycles_of(issue_class, issue_len, issue_table_cycles, branch_taken,
                            code_read_misaligned, flash_read_timing, prefetch_enable);

  // Plain countdown of clocks, no machine cycles. see RQ2
  assign near_done = (cnt_reg <= CNT_ONE);
  assign bp_stop = issue_valid && (|bpb.hit) && !bp_skip_reg && state_reg == ST_RUN; // see RQ9
  assign halt_now = state_reg == ST_RUN && near_done && (halt_pend_reg || bp_stop); // see RQ16

  // Next issue overlaps the last cycle of the current one. see RQ7
  always_comb begin
    issue_ready = 1'b0;
    unique case (state_reg)
      ST_RUN: issue_ready = near_done && !halt_pend_reg && !bp_stop;
      ST_STEP: issue_ready = (cnt_reg == CNT_ZERO);
      ST_HALTED: issue_ready = 1'b0;
      default: issue_ready = 1'b0;
    endcase
  end

  assign accept = issue_valid && issue_ready;

  always_comb begin
    if (accept) begin
      cnt_next = cycles;
    end else if (cnt_reg != CNT_ZERO) begin
      cnt_next = cnt_reg - CNT_ONE;
    end else begin
      cnt_next = CNT_ZERO;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= CNT_ZERO;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // Run control driven by two-wire debug requests and breakpoint hits. see RQ11
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ST_RUN;
    end else begin
      unique case (state_reg)
        ST_RUN: if (halt_now) state_reg <= ST_HALTED; // see RQ16
        ST_HALTED: begin
          if (dbg_step_req) begin
            state_reg <= ST_STEP; // see RQ9
          end else if (dbg_resume_req) begin
            state_reg <= ST_RUN;
          end
        end
        // Stepped instruction may be an interrupt vector entry; same path.
        ST_STEP: if (accept) state_reg <= ST_RUN;
        default: state_reg <= ST_HALTED;
      endcase
    end
  end

  // Request set wins over the clear taken on entry to halt.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      halt_pend_reg <= 1'b0;
    end else if ((dbg_halt_req && state_reg != ST_HALTED) || (state_reg == ST_STEP && accept)) begin
      halt_pend_reg <= 1'b1;
    end else if (halt_now) begin
      halt_pend_reg <= 1'b0;
    end
  end

  // Let the instruction sitting on a breakpoint run once after resume or step.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      bp_skip_reg <= 1'b0;
    end else if (state_reg == ST_HALTED && (dbg_step_req || dbg_resume_req)) begin
      bp_skip_reg <= 1'b1;
    end else if (accept) begin
      bp_skip_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      halt_by_bp_reg <= 1'b0;
    end else if (halt_now) begin
      halt_by_bp_reg <= bp_stop && !halt_pend_reg;
    end
  end

  // Flash byte write or erase through the external-data move. see RQ8
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      flash_write_stb_reg <= 1'b0;
      flash_erase_stb_reg <= 1'b0;
      flash_addr_reg <= ADDR_RESET;
      flash_wdata_reg <= RAM_RESET_DATA;
    end else begin
      flash_write_stb_reg <= accept && issue_class == CLS_FLASH_WR; // see RQ15
      flash_erase_stb_reg <= accept && issue_class == CLS_FLASH_ER; // see RQ15
      if (accept && (issue_class == CLS_FLASH_WR || issue_class == CLS_FLASH_ER)) begin
        flash_addr_reg <= xdata_addr;
        flash_wdata_reg <= xdata_wdata;
      end
    end
  end

  // Debug port owns the RAM only while halted, so it never steals user cycles.
  always_ff @(posedge clk_sys) begin
    if (state_reg == ST_HALTED) begin
      if (dbg_ram_en && dbg_ram_we) begin
        mem[dbg_ram_addr] <= dbg_ram_wdata; // see RQ10
      end
    end else if (ram_en && ram_we) begin
      mem[ram_addr] <= ram_wdata; // see RQ12
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ram_rdata_reg <= RAM_RESET_DATA;
      dbg_ram_rdata_reg <= RAM_RESET_DATA;
    end else begin
      if (ram_en && !ram_we && state_reg != ST_HALTED) begin
        ram_rdata_reg <= mem[ram_addr];
      end
      if (dbg_ram_en && !dbg_ram_we && state_reg == ST_HALTED) begin
        dbg_ram_rdata_reg <= mem[dbg_ram_addr]; // see RQ10
      end
    end
  end

  assign retire = (cnt_reg == CNT_ONE);
  assign busy = (cnt_reg != CNT_ZERO);
  assign halted = (state_reg == ST_HALTED);
  assign halt_by_bp = halt_by_bp_reg;
  assign flash_write_stb = flash_write_stb_reg;
  assign flash_erase_stb = flash_erase_stb_reg;
  assign flash_addr = flash_addr_reg;
  assign flash_wdata = flash_wdata_reg;
  assign ram_rdata = ram_rdata_reg;
  assign dbg_ram_rdata = dbg_ram_rdata_reg;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence s_long_busy;
    state_reg == ST_RUN && cnt_reg > CNT_ONE + CNT_ONE && dbg_halt_req;
  endsequence

  sequence s_step_taken;
    state_reg == ST_STEP && accept;
  endsequence

  AST_LEN_CYCLES: assert property ( // see RQ3
    accept && issue_class == CLS_LEN && prefetch_enable && issue_len != 2'b00
    |=> cnt_reg == {2'b00, $past(issue_len)})
    else $error("length-class instruction cycle count wrong");

  AST_BRANCH_SAVE: assert property ( // see RQ4
    accept && issue_class == CLS_BRANCH && !branch_taken && prefetch_enable
    && issue_table_cycles > BRANCH_NOT_TAKEN_SAVING
    |=> cnt_reg == $past(issue_table_cycles) - BRANCH_NOT_TAKEN_SAVING)
    else $error("untaken branch not two cycles shorter");

  AST_MAX_EIGHT: assert property ( // see RQ5
    accept && prefetch_enable |=> cnt_reg <= MAX_CYCLES && cnt_reg != CNT_ZERO)
    else $error("instruction exceeds eight cycles");

  AST_CODE_READ_RANGE: assert property ( // see RQ14
    accept && issue_class == CLS_CODE_READ && prefetch_enable
    |=> cnt_reg >= CODE_READ_MIN_CYCLES && cnt_reg <= CODE_READ_MAX_CYCLES)
    else $error("code-memory read outside four to seven cycles");

  AST_HALT_FINISH: assert property ( // see RQ16
    s_long_busy |=> !halted ##[1:14] halted)
    else $error("halt did not wait for current instruction");

  AST_STEP_ONE: assert property ( // see RQ9
    s_step_taken |=> !issue_ready ##[0:15] halted)
    else $error("single step did not stop after one instruction");

  AST_BP_BLOCK: assert property ( // see RQ9
    bp_stop |-> !issue_ready ##1 (halted || busy))
    else $error("breakpoint instruction was issued");

  AST_BACK_TO_BACK: assert property ( // see RQ7
    accept && cycles == CNT_ONE ##1 issue_valid && !halt_pend_reg && !bp_stop
    && state_reg == ST_RUN |-> issue_ready)
    else $error("one-cycle instruction stalled next issue");

  AST_FLASH_PULSE: assert property ( // see RQ15
    accept && issue_class == CLS_FLASH_WR |=> flash_write_stb ##1 !flash_write_stb)
    else $error("flash write strobe not a single pulse");

  AST_RAM_RW: assert property ( // see RQ12
    !halted && ram_en && ram_we ##1 !halted && ram_en && !ram_we
    && ram_addr == $past(ram_addr)
    |=> ram_rdata == $past(ram_wdata, 2))
    else $error("data RAM readback mismatch");

endmodule : exec_sequencer

// ### test/dbg_adapter.sv
// Behavioural model of the external debug and flash programming adapter.
// Assumes the same clock as the core; it drives run control and the debug RAM port.
`timescale 1ns/1ps
module dbg_adapter (
  input wire logic clk_sys,
  input wire logic halted,
  input wire logic [7:0] dbg_ram_rdata,
  output logic dbg_halt_req,
  output logic dbg_step_req,
  output logic dbg_resume_req,
  output logic dbg_ram_en,
  output logic dbg_ram_we,
  output logic [7:0] dbg_ram_addr,
  output logic [7:0] dbg_ram_wdata
);
  initial begin
    dbg_halt_req = 1'b0;
    dbg_step_req = 1'b0;
    dbg_resume_req = 1'b0;
    dbg_ram_en = 1'b0;
    dbg_ram_we = 1'b0;
    dbg_ram_addr = 8'h00;
    dbg_ram_wdata = 8'h00;
  end

  // One-cycle request pulse: sel is {halt, step, resume}
  task automatic pulse(input logic [2:0] sel);
    @(posedge clk_sys);
    {dbg_halt_req, dbg_step_req, dbg_resume_req} <= sel;
    @(posedge clk_sys);
    {dbg_halt_req, dbg_step_req, dbg_resume_req} <= 3'b000;
  endtask : pulse

  // Memory access through the debug port only, no user resources involved
  task automatic mem_access(input logic we, input logic [7:0] addr, input logic [7:0] wd,
                            output logic [7:0] rd);
    @(posedge clk_sys);
    dbg_ram_en <= 1'b1;
    dbg_ram_we <= we;
    dbg_ram_addr <= addr;
    dbg_ram_wdata <= wd;
    @(posedge clk_sys);
    dbg_ram_en <= 1'b0;
    dbg_ram_we <= 1'b0;
    // Released data shows the inverse so stale values never look valid
    dbg_ram_wdata <= ~wd;
    @(negedge clk_sys);
    rd = dbg_ram_rdata;
  endtask : mem_access
endmodule : dbg_adapter

// ### test/testbench.sv
// Self-checking bench for the execution sequencer: timing, flash strobes, RAM, debug.
// Assumes the sequencer's assertions live in its own file; one 20 MHz clock.
`timescale 1ns/1ps
module testbench;
  import core_timing_pkg::*;
  logic clk_sys, nrst, issue_valid, issue_ready, branch_taken, code_read_misaligned;
  logic prefetch_enable;
  logic retire, busy, flash_write_stb, flash_erase_stb, halted, halt_by_bp;
  logic dbg_halt_req, dbg_step_req, dbg_resume_req, ram_en, ram_we, dbg_ram_en, dbg_ram_we;
  logic [PC_W-1:0] issue_pc, xdata_addr, flash_addr;
  instr_class_t issue_class;
  logic [1:0] issue_len, flash_read_timing;
  logic [CNT_W-1:0] issue_table_cycles;
  logic [7:0] xdata_wdata, flash_wdata, ram_wdata, ram_rdata, dbg_ram_wdata, dbg_ram_rdata;
  logic [RAM_AW-1:0] ram_addr, dbg_ram_addr;
  logic [NUM_BP*PC_W-1:0] bp_addr;
  logic [NUM_BP-1:0] bp_en;
  logic [25:0] first_cyc;
  logic [31:0] n;
  logic [7:0] rd;
  int mismatches, samples_checked, cycles;

  exec_sequencer dut_u (.clk_sys(clk_sys), .nrst(nrst), .issue_valid(issue_valid),
    .issue_ready(issue_ready), .issue_pc(issue_pc), .issue_class(issue_class),
    .issue_len(issue_len), .issue_table_cycles(issue_table_cycles),
    .branch_taken(branch_taken), .code_read_misaligned(code_read_misaligned),
    .xdata_addr(xdata_addr),
    .xdata_wdata(xdata_wdata), .prefetch_enable(prefetch_enable),
    .flash_read_timing(flash_read_timing), .retire(retire), .busy(busy),
    .flash_write_stb(flash_write_stb), .flash_erase_stb(flash_erase_stb),
    .flash_addr(flash_addr), .flash_wdata(flash_wdata), .dbg_halt_req(dbg_halt_req),
    .dbg_step_req(dbg_step_req), .dbg_resume_req(dbg_resume_req), .bp_addr(bp_addr),
    .bp_en(bp_en), .halted(halted), .halt_by_bp(halt_by_bp), .ram_en(ram_en), .ram_we(ram_we),
    .ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata),
    .dbg_ram_en(dbg_ram_en), .dbg_ram_we(dbg_ram_we), .dbg_ram_addr(dbg_ram_addr),
    .dbg_ram_wdata(dbg_ram_wdata), .dbg_ram_rdata(dbg_ram_rdata));

  dbg_adapter adapter_u (.clk_sys(clk_sys), .halted(halted), .dbg_ram_rdata(dbg_ram_rdata),
    .dbg_halt_req(dbg_halt_req), .dbg_step_req(dbg_step_req),
    .dbg_resume_req(dbg_resume_req), .dbg_ram_en(dbg_ram_en), .dbg_ram_we(dbg_ram_we),
    .dbg_ram_addr(dbg_ram_addr), .dbg_ram_wdata(dbg_ram_wdata));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run

  // Run is far shorter than this; a hang is cut here
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 6000) begin
      mismatches++;
      $display("[ERR] %0t run did not finish", $time);
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Offers one instruction, waits for accept, returns cycles up to retire
  task automatic run_instr(input instr_class_t c, input logic [1:0] l, input logic [3:0] t,
                           input logic tk, input logic mis, input logic [15:0] pc,
                           output logic [31:0] cnt);
    int k;
    logic rdy;
    @(posedge clk_sys);
    issue_valid <= 1'b1;
    issue_class <= c;
    issue_len <= l;
    issue_table_cycles <= t;
    branch_taken <= tk;
    code_read_misaligned <= mis;
    issue_pc <= pc;
    k = 0;
    rdy = 1'b0;
    while (!rdy && k < 40) begin
      @(negedge clk_sys);
      rdy = (issue_ready === 1'b1);
      k++;
      @(posedge clk_sys);
    end
    issue_valid <= 1'b0;
    cnt = 32'h0;
    k = 0;
    while (cnt == 0 && k < 16) begin
      @(negedge clk_sys);
      k++;
      if (k == 1) first_cyc = {flash_write_stb, flash_erase_stb, flash_addr, flash_wdata};
      if (retire === 1'b1) cnt = k;
    end
  endtask : run_instr

  task automatic t_timing();
    for (int l = 1; l <= 3; l++) begin
      run_instr(CLS_LEN, 2'(l), 4'h0, 1'b0, 1'b0, 16'h0100, n);
      chk(n, 32'(l));
    end
    run_instr(CLS_FIXED, 2'h1, 4'h8, 1'b0, 1'b0, 16'h0100, n);
    chk(n, 32'h8);
    run_instr(CLS_FIXED, 2'h1, 4'hf, 1'b0, 1'b0, 16'h0100, n);
    chk(n, 32'h8);
    run_instr(CLS_BRANCH, 2'h2, 4'h5, 1'b1, 1'b0, 16'h0100, n);
    chk(n, 32'h5);
    run_instr(CLS_BRANCH, 2'h2, 4'h5, 1'b0, 1'b0, 16'h0100, n);
    chk(n, 32'h3);
    run_instr(CLS_CODE_READ, 2'h1, 4'h0, 1'b0, 1'b0, 16'h0100, n);
    chk(n, 32'h4);
    for (int f = 0; f < 4; f++) begin
      @(posedge clk_sys);
      flash_read_timing <= 2'(f);
      run_instr(CLS_CODE_READ, 2'h1, 4'h0, 1'b0, 1'b1, 16'h0100, n);
      chk(n, (f < 2) ? 32'(5 + f) : 32'h7);
    end
    @(posedge clk_sys);
    flash_read_timing <= 2'h0;
    prefetch_enable <= 1'b0;
    run_instr(CLS_LEN, 2'h2, 4'h0, 1'b0, 1'b0, 16'h0100, n);
    chk(n, 32'h3);
    @(posedge clk_sys);
    prefetch_enable <= 1'b1;
  endtask : t_timing

  // One-byte instructions must issue on consecutive edges
  task automatic t_back_to_back();
    @(posedge clk_sys);
    issue_valid <= 1'b1;
    issue_class <= CLS_LEN;
    issue_len <= 2'h1;
    issue_pc <= 16'h0100;
    @(negedge clk_sys);
    chk({31'h0, issue_ready}, 32'h1);
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk({30'h0, retire, issue_ready}, 32'h3);
    @(posedge clk_sys);
    issue_valid <= 1'b0;
    @(negedge clk_sys);
    chk({30'h0, retire, busy}, 32'h3);
  endtask : t_back_to_back

  task automatic t_flash_ram();
    @(posedge clk_sys);
    xdata_addr <= 16'h1234;
    xdata_wdata <= 8'h5a;
    run_instr(CLS_FLASH_WR, 2'h2, 4'h0, 1'b0, 1'b0, 16'h0100, n);
    chk(n, 32'h2);
    chk({6'h0, first_cyc}, {6'h0, 2'b10, 16'h1234, 8'h5a});
    run_instr(CLS_FLASH_ER, 2'h1, 4'h0, 1'b0, 1'b0, 16'h0100, n);
    chk({14'h0, first_cyc[25:8]}, {14'h0, 2'b01, 16'h1234});
    @(posedge clk_sys);
    ram_en <= 1'b1;
    ram_we <= 1'b1;
    ram_addr <= 8'hff;
    ram_wdata <= 8'h3c;
    @(posedge clk_sys);
    ram_we <= 1'b0;
    ram_wdata <= 8'hc3;
    @(posedge clk_sys);
    ram_en <= 1'b0;
    @(negedge clk_sys);
    chk({24'h0, ram_rdata}, 32'h3c);
  endtask : t_flash_ram

  task automatic t_debug();
    fork
      run_instr(CLS_FIXED, 2'h1, 4'h4, 1'b0, 1'b0, 16'h0100, n);
      begin
        repeat (20) if (busy !== 1'b1) @(negedge clk_sys);
        adapter_u.pulse(3'b100);
      end
    join
    chk(n, 32'h4);
    @(negedge clk_sys);
    chk({30'h0, halted, halt_by_bp}, 32'h2);
    adapter_u.mem_access(1'b1, 8'hff, 8'ha5, rd);
    adapter_u.mem_access(1'b0, 8'hff, 8'h00, rd);
    chk({24'h0, rd}, 32'ha5);
    fork
      run_instr(CLS_LEN, 2'h1, 4'h0, 1'b0, 1'b0, 16'h0200, n);
      adapter_u.pulse(3'b010);
    join
    chk(n, 32'h1);
    @(negedge clk_sys);
    chk({31'h0, halted}, 32'h1);
    adapter_u.pulse(3'b001);
    @(negedge clk_sys);
    chk({31'h0, halted}, 32'h0);
    // Resume arms a one-shot breakpoint skip; spend it before arming a breakpoint
    run_instr(CLS_LEN, 2'h1, 4'h0, 1'b0, 1'b0, 16'h0100, n);
    chk(n, 32'h1);
    @(posedge clk_sys);
    bp_addr[15:0] <= 16'h0040;
    bp_en <= 4'h1;
    fork
      run_instr(CLS_LEN, 2'h1, 4'h0, 1'b0, 1'b0, 16'h0040, n);
      begin
        repeat (20) if (halted !== 1'b1) @(negedge clk_sys);
        chk({30'h0, halted, halt_by_bp}, 32'h3);
        adapter_u.pulse(3'b001);
      end
    join
    chk(n, 32'h1);
    @(posedge clk_sys);
    bp_en <= 4'h0;
  endtask : t_debug

  initial begin
    nrst = 1'b0;
    issue_valid = 1'b0;
    issue_pc = 16'h0000;
    issue_class = CLS_LEN;
    issue_len = 2'h1;
    issue_table_cycles = 4'h0;
    branch_taken = 1'b0;
    code_read_misaligned = 1'b0;
    xdata_addr = 16'h0000;
    xdata_wdata = 8'h00;
    prefetch_enable = 1'b1;
    flash_read_timing = 2'h0;
    bp_addr = '0;
    bp_en = 4'h0;
    ram_en = 1'b0;
    ram_we = 1'b0;
    ram_addr = 8'h00;
    ram_wdata = 8'h00;
    mismatches = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    t_timing();
    t_back_to_back();
    t_flash_ram();
    t_debug();
    complete_run();
  end
endmodule : testbench
